// File: hw/gpcfg_pkg.sv
// constants and types for the gpio port configuration block
// Overview of operation
// RULE1 - software floats analog pins before sampling
// RULE2 - wait keeps pins; pin interrupt wakes
// RULE3 - halt keeps pins; pin interrupt wakes
// RULE4 - interrupt needs interrupt mode, cpu mask clear
// RULE5 - standard pins: float, pullup, od, pushpull
// RULE6 - pullup irq pins: 0,1 is pullup interrupt
// RULE7 - no-pullup irq pins: 0,1 floating interrupt
// RULE8 - true open drain: direction bit only
// RULE9 - software changes modes via safe states
// RULE10 - input pin read returns live level
// RULE11 - output pin drives and reads latch
// RULE12 - request latch hidden, cleared on fetch
// RULE13 - qualify per pin, OR per vector
// RULE14 - reset clears direction, option, data
package gpcfg_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_OPT = 8'h08;
  localparam logic [7:0] OFF_SENS = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_PIN = 8'h18;
  // reset values
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [3:0] RST_SENS = 4'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // previous pin level idles high, so reset is never seen as a rising edge
  localparam logic [7:0] RST_PREV = 8'hff;
  // pin kinds
  localparam logic [1:0] KIND_STD = 2'h0;
  localparam logic [1:0] KIND_IRQ_PU = 2'h1;
  localparam logic [1:0] KIND_IRQ_NOPU = 2'h2;
  localparam logic [1:0] KIND_TOD = 2'h3;
  // pins 7:6 true open drain, 5:4 standard, 3 irq no pullup, 2:0 irq with pullup
  localparam logic [15:0] PIN_KINDS = 16'hf095;
  // vector of each irq pin: pins 2:0 on vector 0, pin 3 on vector 1
  localparam logic [7:0] VEC1_PINS = 8'h08;
  localparam logic [7:0] VEC0_PINS = 8'h07;
  // sensitivity codes, two bits per vector
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE = 2'h1;
  localparam logic [1:0] SENS_FALL = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;
  // status bit positions
  localparam int STAT_VEC0 = 0;
  localparam int STAT_VEC1 = 1;
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_WAIT = 3'b010,
    PWR_HALT = 3'b100
  } gpcfg_pwr_t;
endpackage

// File: hw/gpcfg_pin_cell.sv
// one pin: mode decode, pad controls and interrupt qualification
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pin_cell #(
  parameter logic [1:0] KIND = gpcfg_pkg::KIND_STD
) (
  // configuration
  input wire logic dir,
  input wire logic opt,
  input wire logic data,
  input wire logic [1:0] sens,
  // pin levels
  input wire logic pin_now,
  input wire logic pin_prev,
  // pad controls
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pull,
  // interrupt
  output logic irq_qual
);
  logic irq_mode;
  logic od;
  always_comb begin
    od = (KIND == gpcfg_pkg::KIND_TOD) ? 1'b1 : ~opt; // RULE8
    pad_out = od ? 1'b0 : data; // RULE11
    pad_oe = dir & (od ? ~data : 1'b1); // RULE5
    pad_pull = 1'b0;
    irq_mode = 1'b0;
    if (!dir && opt) begin
      case (KIND)
        gpcfg_pkg::KIND_STD: pad_pull = 1'b1; // RULE5
        gpcfg_pkg::KIND_IRQ_PU: begin
          pad_pull = 1'b1; // RULE6
          irq_mode = 1'b1;
        end
        gpcfg_pkg::KIND_IRQ_NOPU: irq_mode = 1'b1; // RULE7
        default: irq_mode = 1'b0; // RULE8
      endcase
    end
    // edge or level per sensitivity, only in interrupt input mode
    case (sens)
      gpcfg_pkg::SENS_FALL_LOW: irq_qual = irq_mode & ~pin_now; // RULE13
      gpcfg_pkg::SENS_RISE: irq_qual = irq_mode & pin_now & ~pin_prev;
      gpcfg_pkg::SENS_FALL: irq_qual = irq_mode & ~pin_now & pin_prev;
      default: irq_qual = irq_mode & (pin_now ^ pin_prev);
    endcase
  end
endmodule
`default_nettype wire

// File: hw/gpcfg_port.sv
// gpio port with configuration registers and external interrupt vectors
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gpcfg_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pull,
  // cpu side
  input wire logic cpu_irq_mask,
  input wire logic [1:0] vector_fetch,
  input wire logic enter_wait,
  input wire logic enter_halt,
  output logic [1:0] ext_irq_req,
  output logic cpu_wake,
  output logic irq
);
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] opt_q;
  logic [3:0] sens_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [1:0] req_q;
  logic [7:0] prev_q;
  gpcfg_pkg::gpcfg_pwr_t pwr_q;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic [7:0] pad_pull;
  logic [7:0] qual;
  logic [1:0] vec_hit;
  logic setup;
  logic wr_en;
  logic sens_wr;
  logic mapped;
  logic [31:0] rd_d;
  logic [7:0] rd_data;
  logic wake_d;

  // pin cells, one per pin with its fixed kind
  for (genvar i = 0; i < 8; i++) begin : g_pin
    gpcfg_pin_cell #(
      .KIND(gpcfg_pkg::PIN_KINDS[2*i +: 2])
    ) u_cell (
      .dir(dir_q[i]),
      .opt(opt_q[i]),
      .data(data_q[i]),
      .sens(gpcfg_pkg::VEC1_PINS[i] ? sens_q[3:2] : sens_q[1:0]),
      .pin_now(pin_i[i]),
      .pin_prev(prev_q[i]),
      .pad_out(pad_out[i]),
      .pad_oe(pad_oe[i]),
      .pad_pull(pad_pull[i]),
      .irq_qual(qual[i])
    );
  end

  // qualified requests of one vector are ORed
  assign vec_hit[0] = |(qual & gpcfg_pkg::VEC0_PINS); // RULE13
  assign vec_hit[1] = |(qual & gpcfg_pkg::VEC1_PINS); // RULE13

  // apb decode
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  assign sens_wr = wr_en && (paddr == gpcfg_pkg::OFF_SENS);

  // input pins read live level, output pins read the latch
  assign rd_data = (dir_q & data_q) | (~dir_q & pin_i); // RULE10 RULE11

  always_comb begin
    rd_d = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == gpcfg_pkg::OFF_DATA) begin
      rd_d[7:0] = rd_data;
    end else if (paddr == gpcfg_pkg::OFF_DIR) begin
      rd_d[7:0] = dir_q;
    end else if (paddr == gpcfg_pkg::OFF_OPT) begin
      rd_d[7:0] = opt_q;
    end else if (paddr == gpcfg_pkg::OFF_SENS) begin
      rd_d[3:0] = sens_q;
    end else if (paddr == gpcfg_pkg::OFF_STAT) begin
      rd_d[1:0] = stat_q;
    end else if (paddr == gpcfg_pkg::OFF_MASK) begin
      rd_d[1:0] = mask_q;
    end else if (paddr == gpcfg_pkg::OFF_PIN) begin
      rd_d[7:0] = pin_i;
    end else begin
      mapped = 1'b0;
    end
  end

  // no wait state: answer registered in the setup cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      // unmapped writes answer zero data as well
      if (setup && (!pwrite || !mapped)) begin
        prdata <= rd_d;
      end
    end
  end

  // configuration registers; the latch may be preloaded before output mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_q <= gpcfg_pkg::RST_PORT; // RULE14
      dir_q <= gpcfg_pkg::RST_PORT; // RULE14
      opt_q <= gpcfg_pkg::RST_PORT; // RULE14
      sens_q <= gpcfg_pkg::RST_SENS;
      mask_q <= gpcfg_pkg::RST_IRQ;
    end else if (wr_en) begin
      if (paddr == gpcfg_pkg::OFF_DATA) begin
        data_q <= pwdata[7:0]; // RULE11
      end else if (paddr == gpcfg_pkg::OFF_DIR) begin
        dir_q <= pwdata[7:0];
      end else if (paddr == gpcfg_pkg::OFF_OPT) begin
        opt_q <= pwdata[7:0];
      end else if (paddr == gpcfg_pkg::OFF_SENS) begin
        sens_q <= pwdata[3:0];
      end else if (paddr == gpcfg_pkg::OFF_MASK) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  // previous pin level for edge detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= gpcfg_pkg::RST_PREV;
    end else begin
      prev_q <= pin_i;
    end
  end

  // hidden request latch: set wins over vector fetch and sensitivity write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req_q <= gpcfg_pkg::RST_IRQ;
    end else begin
      for (int v = 0; v < 2; v++) begin
        if (vec_hit[v]) begin
          req_q[v] <= 1'b1; // RULE13
        end else if (vector_fetch[v] || sens_wr) begin
          req_q[v] <= 1'b0; // RULE12
        end
      end
    end
  end

  // sticky software status, write one to clear, set wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= gpcfg_pkg::RST_IRQ;
    end else begin
      for (int v = 0; v < 2; v++) begin
        if (vec_hit[v]) begin
          stat_q[v] <= 1'b1;
        end else if (wr_en && paddr == gpcfg_pkg::OFF_STAT && pwdata[v]) begin
          stat_q[v] <= 1'b0;
        end
      end
    end
  end

  // cpu request only while the cpu mask is clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_irq_req <= 2'b00;
      irq <= 1'b0;
    end else begin
      ext_irq_req <= req_q & {2{~cpu_irq_mask}}; // RULE4
      irq <= |(stat_q & mask_q);
    end
  end

  // low power tracking; config and pads are never touched here
  assign wake_d = |req_q & ~cpu_irq_mask;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_q <= gpcfg_pkg::PWR_RUN;
      cpu_wake <= 1'b0;
    end else begin
      cpu_wake <= 1'b0;
      case (pwr_q)
        gpcfg_pkg::PWR_RUN: begin
          if (enter_halt) begin
            pwr_q <= gpcfg_pkg::PWR_HALT;
          end else if (enter_wait) begin
            pwr_q <= gpcfg_pkg::PWR_WAIT;
          end
        end
        gpcfg_pkg::PWR_WAIT: begin
          if (wake_d) begin
            pwr_q <= gpcfg_pkg::PWR_RUN; // RULE2
            cpu_wake <= 1'b1;
          end
        end
        gpcfg_pkg::PWR_HALT: begin
          if (wake_d) begin
            pwr_q <= gpcfg_pkg::PWR_RUN; // RULE3
            cpu_wake <= 1'b1;
          end
        end
        default: pwr_q <= gpcfg_pkg::PWR_RUN;
      endcase
    end
  end

  // pad drive registered; a low power state does not alter it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_o <= 8'h00;
      pin_oe <= 8'h00;
      pin_pull <= 8'h00;
    end else begin
      pin_o <= pad_out; // RULE2 RULE3
      pin_oe <= pad_oe;
      pin_pull <= pad_pull;
    end
  end
endmodule
`default_nettype wire

// File: tb/gpcfg_port_properties.sv
// concurrent checks on the port pads and apb answers
`timescale 1ns/1ps
`default_nettype none
module gpcfg_port_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pull,
  // cpu side
  input wire logic cpu_irq_mask,
  input wire logic [1:0] vector_fetch,
  input wire logic [1:0] ext_irq_req,
  input wire logic cpu_wake
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  // pin held high across the fetch: no edge or level can re-arm
  sequence fetch_quiet_s;
    vector_fetch[1] && pin_i[3] && $stable(pin_i[3]) ##1 $stable(pin_i[3]);
  endsequence
  a_ready_one_wait: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer without ready or with data");
  a_req_cpu_mask: assert property (|ext_irq_req |-> !$past(cpu_irq_mask))
    else $error("request raised while cpu mask set");
  a_fetch_clears_req: assert property (fetch_quiet_s |=> !ext_irq_req[1])
    else $error("request kept after vector fetch");
  a_wake_one_pulse: assert property (cpu_wake |=> !cpu_wake)
    else $error("wake pulse longer than one cycle");
  a_tod_sinks_only: assert property ((pin_oe[7:6] & pin_o[7:6]) == 2'b00)
    else $error("true open drain pin drives high");
  a_pull_input_only: assert property ((pin_pull & (pin_oe | 8'hc8)) == 8'h00)
    else $error("pull-up on output or pull-less pin");
  a_pads_need_write: assert property ($changed({pin_o, pin_oe, pin_pull})
    |-> $past(psel && penable && pwrite && pready, 2))
    else $error("pads changed without a register write");
endmodule
bind gpcfg_port gpcfg_port_properties gpcfg_port_properties_inst (.ref_clk, .resetn,
  .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe,
  .pin_pull, .cpu_irq_mask, .vector_fetch, .ext_irq_req, .cpu_wake);
`default_nettype wire

// File: tb/gpcfg_board.sv
// far side model: board levels on the port pins
`timescale 1ns/1ps
`default_nettype none
module gpcfg_board (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // pads from the port
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pull,
  // bench commands
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_lvl,
  // resolved levels
  output logic [7:0] pin_i
);
  logic [7:0] float_q;
  // undriven pins wander so nothing leans on a settled float
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      float_q <= 8'h00;
    else
      float_q <= ~float_q;
  end
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_drv & ext_lvl)
    | (~pin_oe & ~ext_drv & (pin_pull | float_q));
endmodule
`default_nettype wire

// File: tb/tb_gpio_port_config_and_ext_irq.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_port_config_and_ext_irq;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic cpu_irq_mask, enter_wait, enter_halt, cpu_wake;
  logic [1:0] vector_fetch, ext_irq_req;
  logic [7:0] paddr, pin_i, pin_o, pin_oe, pin_pull, ext_drv, ext_lvl, dir, opt, dat;
  logic [31:0] pwdata, prdata, r;
  logic [23:0] pads;
  int n_fail, checks, t;
  int cyc = 0;
  gpcfg_port gpcfg_port_inst (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe, .pin_pull,
    .cpu_irq_mask, .vector_fetch, .enter_wait, .enter_halt, .ext_irq_req, .cpu_wake, .irq);
  gpcfg_board gpcfg_board_inst (.ref_clk, .resetn, .pin_o, .pin_oe, .pin_pull,
    .ext_drv, .ext_lvl, .pin_i);
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one idle cycle after each transfer keeps psel from two writes per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    // ends once pready is seen high; only the bench timeout bounds this wait
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(r, e);
  endtask
  task automatic fetch(input logic [1:0] v);
    vector_fetch <= v;
    @(posedge ref_clk);
    vector_fetch <= 0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, cpu_irq_mask} = 0;
    {vector_fetch, enter_wait, enter_halt, n_fail, checks} = 0;
    ext_drv = 8'hff;
    ext_lvl = 8'hff;
    t = $urandom(32'ha99a);
    repeat (4) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    // data reads the live pins after reset: all inputs, board drives high
    for (int i = 0; i < 6; i++)
      rdc(8'(i * 4), (i == 0) ? 32'h0000_00ff : 32'h0000_0000);
    chk(pin_oe, 0);
    apb(0, 8'h40, 0);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    for (int k = 0; k < 12; k++) begin
      dat = (k == 0) ? 8'h00 : 8'($urandom);
      opt = (k == 1) ? 8'hff : 8'($urandom);
      dir = (k < 2) ? 8'hff : 8'($urandom);
      ext_drv <= ~dir;
      ext_lvl <= 8'($urandom);
      wr(gpcfg_pkg::OFF_DATA, dat);
      wr(gpcfg_pkg::OFF_OPT, opt);
      wr(gpcfg_pkg::OFF_DIR, dir);
      @(posedge ref_clk);
      chk(pin_oe, dir & (~dat | (opt & 8'h3f)));
      chk(pin_pull, ~dir & opt & 8'h37);
      chk(pin_o & pin_oe, dir & opt & dat & 8'h3f);
      rdc(gpcfg_pkg::OFF_DATA, (dir & dat) | (~dir & ext_lvl));
    end
    ext_drv <= 8'hff;
    ext_lvl <= 8'hf7;
    cpu_irq_mask <= 1;
    // leave interrupt mode first; the sensitivity write then drops stale latches
    wr(gpcfg_pkg::OFF_OPT, 32'h0000_0000);
    wr(gpcfg_pkg::OFF_DIR, 0);
    wr(gpcfg_pkg::OFF_SENS, 32'h0000_0006);
    wr(gpcfg_pkg::OFF_OPT, 8'h0f);
    wr(gpcfg_pkg::OFF_STAT, 3);
    wr(gpcfg_pkg::OFF_MASK, 2);
    ext_lvl <= 8'hff;
    repeat (3) @(posedge ref_clk);
    chk(ext_irq_req, 0);
    chk(irq, 1);
    cpu_irq_mask <= 0;
    repeat (2) @(posedge ref_clk);
    chk(ext_irq_req, 2);
    fetch(2);
    chk(ext_irq_req, 0);
    wr(gpcfg_pkg::OFF_STAT, 2);
    // irq is registered one edge after the clear
    @(posedge ref_clk);
    chk(irq, 0);
    // pin 3 back to a plain input: edges must be ignored
    wr(gpcfg_pkg::OFF_OPT, 8'h07);
    ext_lvl <= 8'hf7;
    repeat (2) @(posedge ref_clk);
    ext_lvl <= 8'hff;
    repeat (3) @(posedge ref_clk);
    chk(ext_irq_req, 0);
    rdc(gpcfg_pkg::OFF_STAT, 0);
    for (int m = 0; m < 2; m++) begin
      {enter_halt, enter_wait} <= 2'(1 << m);
      @(posedge ref_clk);
      {enter_halt, enter_wait} <= 0;
      pads = {pin_o, pin_oe, pin_pull};
      ext_lvl <= ~8'(1 << m);
      t = 0;
      while (cpu_wake !== 1'b1 && t < 12) begin
        @(posedge ref_clk);
        t++;
      end
      chk(t < 12, 1);
      chk(ext_irq_req, 1);
      chk({pin_o, pin_oe, pin_pull}, pads);
      chk(irq, 0);
      fetch(1);
      ext_lvl <= 8'hff;
      wr(gpcfg_pkg::OFF_STAT, 3);
    end
    rdc(gpcfg_pkg::OFF_PIN, 32'h0000_00ff);
    // both edges on vector 0, pin 2 falls then rises
    wr(gpcfg_pkg::OFF_SENS, 32'h0000_0003);
    ext_lvl <= 8'hfb;
    repeat (3) @(posedge ref_clk);
    chk(ext_irq_req, 32'h0000_0001);
    fetch(1);
    chk(ext_irq_req, 32'h0000_0000);
    ext_lvl <= 8'hff;
    repeat (3) @(posedge ref_clk);
    chk(ext_irq_req, 32'h0000_0001);
    fetch(1);
    // low level keeps re-arming: the event beats the fetch
    wr(gpcfg_pkg::OFF_SENS, 32'h0000_0000);
    ext_lvl <= 8'hfb;
    repeat (2) @(posedge ref_clk);
    fetch(1);
    chk(ext_irq_req, 32'h0000_0001);
    ext_lvl <= 8'hff;
    fetch(1);
    chk(ext_irq_req, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
